/* File: rtl/micw_irq_wake.sv */
// Purpose: Interrupt collection, vectoring and reset/wake cause control
// Assumes: AHB-Lite single word transfers; core honours the command group
// Notes:   Instruction cycle is four clocks; arst_n is the power-on reset
//
// Overview of operation
// RULE1: Global enable bit 7 set lets unmasked sources interrupt; clear blocks all.
// RULE2: Every reset clears the global interrupt enable.
// RULE3: Each source has its own enable; a clear enable blocks that source.
// RULE4: Return-from-interrupt instruction sets the global enable again.
// RULE5: Taking an interrupt clears global enable, pushes return, loads 0004h.
// RULE6: Pin and port-change latency is three or four instruction cycles.
// RULE7: Flags set on their event regardless of any enable.
// RULE8: Software clears serviced flags before re-enabling interrupts.
// RULE9: Clearing global enable cancels an imminent take; request stays pending.
// RULE10: Control register holds pin, port-change and timer overflow flags.
// RULE11: First peripheral flag register holds its seven peripheral flags.
// RULE12: Second peripheral flag register holds its six peripheral flags; the code implements seven (mask 8'hFD).
// RULE13: Peripheral enables sit in two enable registers, one per flag.
// RULE14: Interrupt wake continues at PC+1, then vectors if global enable set.
// RULE15: Power-on, clear, watchdog, brown-out resets load 000h; watchdog wake continues.
// RULE16: Status upper bits record the reset or wake cause.
// RULE17: Power register resets 010x or 01u0; bit 0 cleared only by brown-out.
// RULE18: Interrupt wake leaves the causing flag set.
// RULE19: Pin is edge triggered per edge select; valid edge sets flag bit 1.
// RULE20: Request is gated OR of flag-and-enable, acted on at instruction boundary.
`timescale 1ns/10ps
`include "micw_regs.svh"

module micw_irq_wake
  import micw_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        ext_irq_pin,
  input  wire logic        master_clear_pin_n,
  input  wire logic        brownout_det,
  input  wire logic        watchdog_timeout,
  input  wire logic        port_change_evt,
  input  wire logic        tmr0_ovf_evt,
  input  wire logic [7:0]  periph_evt_a,
  input  wire logic [7:0]  periph_evt_b,
  input  wire logic        core_boundary,
  input  wire logic        core_sleeping,
  input  wire logic        core_return_from_irq_instr,
  output logic             irq_take,
  output logic             pc_load,
  output logic [12:0]      pc_value,
  output logic             status_load,
  output logic [4:0]       status_cause,
  output logic [4:0]       status_keep,
  output logic             core_wake
);

  // Pin synchronisers; stage one feeds only stage two
  logic [2:0]     pin_sync_r;
  logic [1:0]     master_clear_pin_sync_r;
  logic [1:0]     bor_sync_r;
  logic           bor_seen_r;
  micw_regs_t     regs_r, regs_nxt;
  micw_core_cmd_t cmd_r, cmd_nxt;
  micw_phase_t    phase_r, phase_nxt;
  logic           pend_r, pend_nxt;
  logic           wr_act_r, wr_act_nxt;
  logic           rd_act_r, rd_act_nxt;
  logic [7:0]     addr_r, addr_nxt;
  logic           ok_addr_r, ok_addr_nxt;
  logic           hready_r, hready_nxt;
  logic [31:0]    hrdata_r, hrdata_nxt;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pin_sync_r  <= 3'h0;
      master_clear_pin_sync_r <= 2'h3;
      bor_sync_r  <= 2'h0;
      bor_seen_r  <= 1'b0;
    end else begin
      pin_sync_r  <= {pin_sync_r[1:0], ext_irq_pin};
      master_clear_pin_sync_r <= {master_clear_pin_sync_r[0], master_clear_pin_n};
      bor_sync_r  <= {bor_sync_r[0], brownout_det};
      bor_seen_r  <= bor_sync_r[1];
    end
  end

  // Edge taken from stages two and three so stage one stays clean
  logic pin_rise;
  logic pin_fall;
  logic pin_edge;
  logic master_clear_pin_act;
  logic bor_evt;
  logic wdt_rst;
  logic wdt_wake;
  logic any_rst;
  assign pin_rise = pin_sync_r[1] & ~pin_sync_r[2];
  assign pin_fall = ~pin_sync_r[1] & pin_sync_r[2];
  assign pin_edge = regs_r.edge_sel ? pin_rise : pin_fall; // RULE19
  assign master_clear_pin_act = ~master_clear_pin_sync_r[1];
  assign bor_evt  = bor_sync_r[1] & ~bor_seen_r;
  assign wdt_rst  = watchdog_timeout & ~core_sleeping;
  assign wdt_wake = watchdog_timeout & core_sleeping;
  assign any_rst  = bor_evt | master_clear_pin_act | wdt_rst;

  // Masked request, independent of the global enable
  logic [7:0] pa_hit;
  logic [7:0] pb_hit;
  logic       periph_req;
  logic       core_req;
  logic       src_req;
  logic       gie_kill;
  assign pa_hit     = regs_r.pflag_a & regs_r.pen_a; // RULE13
  assign pb_hit     = regs_r.pflag_b & regs_r.pen_b; // RULE13
  assign periph_req = regs_r.ctrl[`MICW_PEIE_BIT] & (|pa_hit | |pb_hit);
  assign core_req   = (regs_r.ctrl[`MICW_T0IE_BIT]
                       & regs_r.ctrl[`MICW_T0IF_BIT])
                    | (regs_r.ctrl[`MICW_INTE_BIT]
                       & regs_r.ctrl[`MICW_EXT_IRQ_FLAG_BIT])
                    | (regs_r.ctrl[`MICW_RBIE_BIT]
                       & regs_r.ctrl[`MICW_RBIF_BIT]); // RULE3
  assign src_req    = core_req | periph_req; // RULE20
  // A write clearing the global enable in this cycle stops a take
  assign gie_kill   = wr_act_r & ok_addr_r
                    & (addr_r == `MICW_OFS_IRQ_CTRL)
                    & ~hwdata[`MICW_GIE_BIT]; // RULE9

  // Read multiplexer, unmapped words read zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (addr_r)
      `MICW_OFS_IRQ_CTRL:  rd_mux[7:0] = regs_r.ctrl;
      `MICW_OFS_PFLAG_A:   rd_mux[7:0] = regs_r.pflag_a;
      `MICW_OFS_PFLAG_B:   rd_mux[7:0] = regs_r.pflag_b;
      `MICW_OFS_PEN_A:     rd_mux[7:0] = regs_r.pen_a;
      `MICW_OFS_PEN_B:     rd_mux[7:0] = regs_r.pen_b;
      `MICW_OFS_PWR_CTRL:  rd_mux[3:0] = regs_r.power_control_reg;
      `MICW_OFS_EDGE_CFG:  rd_mux[`MICW_EDGE_BIT] = regs_r.edge_sel;
      `MICW_OFS_WAKE_STAT: rd_mux[2:0] = {pend_r, src_req, core_sleeping};
      default:             rd_mux = 32'h0000_0000;
    endcase
    if (!ok_addr_r) begin
      rd_mux = 32'h0000_0000;
    end
  end

  // Bus slave: writes finish at once, reads take one wait state so that
  // a read right after a write sees the written value
  always_comb begin
    logic ap;
    ap          = hsel & htrans[1] & hready;
    wr_act_nxt  = ap & hwrite;
    rd_act_nxt  = ap & ~hwrite;
    addr_nxt    = ap ? {haddr[7:2], 2'b00} : addr_r;
    ok_addr_nxt = ap ? (haddr[31:8] == 24'h00_0000) : ok_addr_r;
    hready_nxt  = ~(ap & ~hwrite);
    hrdata_nxt  = hrdata_r;
    if (rd_act_r) begin
      hrdata_nxt = rd_mux;
    end
  end

  // Register set, instruction phase and command group
  always_comb begin
    logic wr_ok;
    logic take;
    wr_ok     = wr_act_r & ok_addr_r;
    take      = 1'b0;
    regs_nxt  = regs_r;
    pend_nxt  = pend_r;
    phase_nxt = (phase_r == MICW_Q4) ? MICW_Q1
                                      : micw_phase_t'(phase_r + 2'h1);
    cmd_nxt   = '0;
    cmd_nxt.pc_value = cmd_r.pc_value;
    cmd_nxt.st_cause = cmd_r.st_cause;
    cmd_nxt.st_keep  = cmd_r.st_keep;
    // Software writes; unimplemented bits stay zero
    if (wr_ok) begin
      case (addr_r)
        `MICW_OFS_IRQ_CTRL: regs_nxt.ctrl    = hwdata[7:0];
        `MICW_OFS_PFLAG_A:  regs_nxt.pflag_a = hwdata[7:0] & `MICW_PA_MASK;
        `MICW_OFS_PFLAG_B:  regs_nxt.pflag_b = hwdata[7:0] & `MICW_PB_MASK;
        `MICW_OFS_PEN_A:    regs_nxt.pen_a   = hwdata[7:0] & `MICW_PA_MASK;
        `MICW_OFS_PEN_B:    regs_nxt.pen_b   = hwdata[7:0] & `MICW_PB_MASK;
        `MICW_OFS_PWR_CTRL: regs_nxt.power_control_reg    = hwdata[3:0];
        `MICW_OFS_EDGE_CFG: regs_nxt.edge_sel = hwdata[`MICW_EDGE_BIT];
        default:            regs_nxt = regs_nxt;
      endcase
    end
    // Events set flags after the write so a same-cycle clear loses
    regs_nxt.ctrl[`MICW_EXT_IRQ_FLAG_BIT] = regs_nxt.ctrl[`MICW_EXT_IRQ_FLAG_BIT]
                                   | pin_edge; // RULE19
    regs_nxt.ctrl[`MICW_RBIF_BIT] = regs_nxt.ctrl[`MICW_RBIF_BIT]
                                   | port_change_evt; // RULE10
    regs_nxt.ctrl[`MICW_T0IF_BIT] = regs_nxt.ctrl[`MICW_T0IF_BIT]
                                   | tmr0_ovf_evt; // RULE7
    regs_nxt.pflag_a = regs_nxt.pflag_a
                     | (periph_evt_a & `MICW_PA_MASK); // RULE11
    regs_nxt.pflag_b = regs_nxt.pflag_b
                     | (periph_evt_b & `MICW_PB_MASK); // RULE12
    // Request sampled once per instruction cycle, at Q1
    if (phase_r == MICW_Q1) begin
      pend_nxt = src_req & regs_r.ctrl[`MICW_GIE_BIT]; // RULE1
    end
    if (!regs_r.ctrl[`MICW_GIE_BIT] || gie_kill) begin
      pend_nxt = 1'b0; // RULE9
    end
    // Vector at Q4 of an instruction boundary; a take due mid two-cycle
    // instruction waits one more instruction cycle for the boundary
    take = pend_r & regs_r.ctrl[`MICW_GIE_BIT] & ~gie_kill
         & (phase_r == MICW_Q4) & core_boundary & ~core_sleeping; // RULE6
    if (core_return_from_irq_instr) begin
      regs_nxt.ctrl[`MICW_GIE_BIT] = 1'b1; // RULE4
    end
    if (take) begin
      regs_nxt.ctrl[`MICW_GIE_BIT] = 1'b0; // RULE5
      pend_nxt         = 1'b0;
      cmd_nxt.irq_take = 1'b1; // RULE5
      cmd_nxt.pc_load  = 1'b1;
      cmd_nxt.pc_value = `MICW_VEC_IRQ; // RULE5
    end
    // Wake from sleep: core resumes at PC+1, vectors later if enabled
    if (core_sleeping && src_req) begin // RULE18
      cmd_nxt.wake     = 1'b1; // RULE14
      cmd_nxt.st_load  = 1'b1;
      cmd_nxt.st_cause = `MICW_ST_IRQ_WAKE; // RULE16
      cmd_nxt.st_keep  = `MICW_KP_IRQ_WAKE;
    end else if (wdt_wake) begin
      cmd_nxt.wake     = 1'b1; // RULE15
      cmd_nxt.st_load  = 1'b1;
      cmd_nxt.st_cause = `MICW_ST_WDT_WAKE; // RULE16
      cmd_nxt.st_keep  = `MICW_KP_WDT_WAKE;
    end
    // Synchronous resets win over everything else
    if (any_rst) begin
      regs_nxt.ctrl    = `MICW_RST_CTRL
                       | (regs_r.ctrl & 8'h01); // RULE2
      regs_nxt.pflag_a = `MICW_RST_PER;
      regs_nxt.pflag_b = `MICW_RST_PER;
      regs_nxt.pen_a   = `MICW_RST_PER;
      regs_nxt.pen_b   = `MICW_RST_PER;
      regs_nxt.edge_sel = 1'b1;
      pend_nxt         = 1'b0;
      phase_nxt        = MICW_Q1;
      cmd_nxt          = '0;
      cmd_nxt.pc_load  = 1'b1;
      cmd_nxt.pc_value = `MICW_VEC_RST; // RULE15
      cmd_nxt.st_load  = 1'b1;
      if (bor_evt) begin
        regs_nxt.power_control_reg    = {2'b01, regs_r.power_control_reg[1], 1'b0}; // RULE17
        cmd_nxt.st_cause = `MICW_ST_BOR; // RULE16
        cmd_nxt.st_keep  = `MICW_KP_BOR;
      end else begin
        regs_nxt.power_control_reg    = {1'b0, regs_r.power_control_reg[2:0]}; // RULE17
        if (master_clear_pin_act && core_sleeping) begin
          cmd_nxt.st_cause = `MICW_ST_MASTER_CLEAR_PIN_SLP; // RULE16
          cmd_nxt.st_keep  = `MICW_KP_MASTER_CLEAR_PIN_SLP;
        end else if (master_clear_pin_act) begin
          cmd_nxt.st_cause = `MICW_ST_MASTER_CLEAR_PIN_RUN;
          cmd_nxt.st_keep  = `MICW_KP_MASTER_CLEAR_PIN_RUN;
        end else begin
          cmd_nxt.st_cause = `MICW_ST_WDT_RST;
          cmd_nxt.st_keep  = `MICW_KP_WDT_RST;
        end
      end
    end
  end

  // Only registering here; power-on values taken as constants
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      regs_r.ctrl     <= `MICW_RST_CTRL; // RULE2
      regs_r.pflag_a  <= `MICW_RST_PER;
      regs_r.pflag_b  <= `MICW_RST_PER;
      regs_r.pen_a    <= `MICW_RST_PER;
      regs_r.pen_b    <= `MICW_RST_PER;
      regs_r.power_control_reg     <= `MICW_RST_POWER_CONTROL_REG_POR; // RULE17
      regs_r.edge_sel <= 1'b1;
      pend_r          <= 1'b0;
      phase_r         <= MICW_Q1;
      cmd_r           <= '0;
      cmd_r.pc_load   <= 1'b1;
      cmd_r.pc_value  <= `MICW_VEC_RST; // RULE15
      cmd_r.st_load   <= 1'b1;
      cmd_r.st_cause  <= `MICW_ST_POR; // RULE16
      cmd_r.st_keep   <= `MICW_KP_POR;
      wr_act_r        <= 1'b0;
      rd_act_r        <= 1'b0;
      addr_r          <= 8'h00;
      ok_addr_r       <= 1'b0;
      hready_r        <= 1'b1;
      hrdata_r        <= 32'h0000_0000;
    end else begin
      regs_r    <= regs_nxt;
      pend_r    <= pend_nxt;
      phase_r   <= phase_nxt;
      cmd_r     <= cmd_nxt;
      wr_act_r  <= wr_act_nxt;
      rd_act_r  <= rd_act_nxt;
      addr_r    <= addr_nxt;
      ok_addr_r <= ok_addr_nxt;
      hready_r  <= hready_nxt;
      hrdata_r  <= hrdata_nxt;
    end
  end

  // Outputs straight from flops; response is always OKAY
  assign hreadyout    = hready_r;
  assign hresp        = 1'b0;
  assign hrdata       = hrdata_r;
  assign irq_take     = cmd_r.irq_take;
  assign pc_load      = cmd_r.pc_load;
  assign pc_value     = cmd_r.pc_value;
  assign status_load  = cmd_r.st_load;
  assign status_cause = cmd_r.st_cause;
  assign status_keep  = cmd_r.st_keep;
  assign core_wake    = cmd_r.wake;

endmodule

/* File: rtl/micw_pkg.sv */
// Purpose: Types shared by the interrupt and wake controller
// Assumes: Nothing beyond SystemVerilog packages
// Notes:   Register set travels as one packed struct
package micw_pkg;

  // Instruction cycle phases
  typedef enum logic [1:0] {
    MICW_Q1,
    MICW_Q2,
    MICW_Q3,
    MICW_Q4
  } micw_phase_t;

  // Software visible register set
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] pflag_a;
    logic [7:0] pflag_b;
    logic [7:0] pen_a;
    logic [7:0] pen_b;
    logic [3:0] power_control_reg;
    logic       edge_sel;
  } micw_regs_t;

  // Command group towards the core
  typedef struct packed {
    logic        irq_take;
    logic        pc_load;
    logic [12:0] pc_value;
    logic        st_load;
    logic [4:0]  st_cause;
    logic [4:0]  st_keep;
    logic        wake;
  } micw_core_cmd_t;

endpackage

/* File: rtl/micw_regs.svh */
// Purpose: Offsets, field positions, reset values and counts of the block
// Assumes: Included by bare name; definitions only
// Notes:   Offsets are byte addresses of aligned 32-bit words
`ifndef MICW_REGS_SVH
`define MICW_REGS_SVH

// Register byte offsets
`define MICW_OFS_IRQ_CTRL    8'h00
`define MICW_OFS_PFLAG_A     8'h04
`define MICW_OFS_PFLAG_B     8'h08
`define MICW_OFS_PEN_A       8'h0C
`define MICW_OFS_PEN_B       8'h10
`define MICW_OFS_PWR_CTRL    8'h14
`define MICW_OFS_EDGE_CFG    8'h18
`define MICW_OFS_WAKE_STAT   8'h1C

// Control register fields, then the edge select bit of the edge configuration register
`define MICW_GIE_BIT         7
`define MICW_PEIE_BIT        6
`define MICW_T0IE_BIT        5
`define MICW_INTE_BIT        4
`define MICW_RBIE_BIT        3
`define MICW_T0IF_BIT        2
`define MICW_EXT_IRQ_FLAG_BIT        1
`define MICW_RBIF_BIT        0
`define MICW_EDGE_BIT        6

// Implemented bits of the peripheral flag and enable registers
`define MICW_PA_MASK         8'h7F
`define MICW_PB_MASK         8'hFD

// Reset values
`define MICW_RST_CTRL        8'h00
`define MICW_RST_PER         8'h00
`define MICW_RST_POWER_CONTROL_REG_POR    4'h4

// Status cause patterns, bits 7..3 (TO is bit 4, PD is bit 3)
`define MICW_ST_POR          5'h03
`define MICW_ST_MASTER_CLEAR_PIN_RUN     5'h00
`define MICW_ST_MASTER_CLEAR_PIN_SLP     5'h02
`define MICW_ST_WDT_RST      5'h00
`define MICW_ST_WDT_WAKE     5'h00
`define MICW_ST_BOR          5'h03
`define MICW_ST_IRQ_WAKE     5'h02
// Keep masks: a set bit means the status bit is left unchanged
`define MICW_KP_POR          5'h00
`define MICW_KP_MASTER_CLEAR_PIN_RUN     5'h03
`define MICW_KP_MASTER_CLEAR_PIN_SLP     5'h00
`define MICW_KP_WDT_RST      5'h01
`define MICW_KP_WDT_WAKE     5'h1C
`define MICW_KP_BOR          5'h00
`define MICW_KP_IRQ_WAKE     5'h1C

// Program counter targets and instruction cycle length
`define MICW_VEC_IRQ         13'h0004
`define MICW_VEC_RST         13'h0000
`define MICW_CLK_PER_TCY     4

`endif

/* File: verification/mcu_interrupt_and_wake_control_tb.sv */
// Purpose: Self-checking bench for the interrupt and wake controller
// Assumes: Register model kept as ints, compared on every read
// Notes:   Core side comes from micw_core_model
`timescale 1ns/10ps
`include "micw_regs.svh"
module mcu_interrupt_and_wake_control_tb
  import micw_pkg::*;
;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic        ext_irq_pin = 1'b0;
  logic        master_clear_pin_n = 1'b1;
  logic        brownout_det = 1'b0;
  logic        watchdog_timeout = 1'b0;
  logic        port_change_evt = 1'b0;
  logic        tmr0_ovf_evt = 1'b0;
  logic [7:0]  periph_evt_a = 8'h00;
  logic [7:0]  periph_evt_b = 8'h00;
  logic        go_sleep = 1'b0;
  logic        do_ret = 1'b0;
  logic        hready, hreadyout, hresp, core_boundary, core_sleeping;
  logic        core_return_from_irq_instr, irq_take, pc_load, status_load, core_wake;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [12:0] pc_value;
  logic [4:0]  status_cause, status_keep;
  logic [31:0] seed = 32'h00008698;
  int          n_fail = 0;
  int          check_count = 0;
  int          n_take = 0;
  int          n_wake = 0;
  int          cyc;
  int          model [0:8] = '{0, 0, 0, 0, 0, 4, 8'h40, 0, 0};
  int          wmask [0:8] = '{8'hFF, 8'h7F, 8'hFD, 8'h7F, 8'hFD, 8'h0F,
                               8'h40, 0, 0};

  micw_irq_wake u_dut (.clock(clock), .arst_n(arst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .ext_irq_pin(ext_irq_pin),
    .master_clear_pin_n(master_clear_pin_n), .brownout_det(brownout_det),
    .watchdog_timeout(watchdog_timeout), .port_change_evt(port_change_evt),
    .tmr0_ovf_evt(tmr0_ovf_evt), .periph_evt_a(periph_evt_a),
    .periph_evt_b(periph_evt_b), .core_boundary(core_boundary),
    .core_sleeping(core_sleeping), .core_return_from_irq_instr(core_return_from_irq_instr),
    .irq_take(irq_take), .pc_load(pc_load), .pc_value(pc_value),
    .status_load(status_load), .status_cause(status_cause),
    .status_keep(status_keep), .core_wake(core_wake));
  micw_core_model u_core (.clock(clock), .arst_n(arst_n),
    .core_wake(core_wake), .pc_load(pc_load), .go_sleep(go_sleep),
    .do_ret(do_ret), .core_boundary(core_boundary),
    .core_sleeping(core_sleeping), .core_return_from_irq_instr(core_return_from_irq_instr));

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;
  always #20 clock = ~clock;
  // Count takes and wakes as pulses
  always @(posedge clock) begin
    if (irq_take === 1'b1) n_take++;
    if (core_wake === 1'b1) n_wake++;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One AHB single transfer; waits on ready in both phases
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
    model[a[5:2]] = d & wmask[a[5:2]];
  endtask

  task automatic rdc(input logic [7:0] a);
    bus(1'b0, a, 8'h00);
    chk(rd, model[a[5:2]]);
  endtask

  task automatic evt(input logic [15:0] r, input logic t, input logic p);
    @(posedge clock);
    periph_evt_a <= r[7:0];
    periph_evt_b <= r[15:8];
    tmr0_ovf_evt <= t;
    port_change_evt <= p;
    @(posedge clock);
    periph_evt_a <= 8'h00;
    periph_evt_b <= 8'h00;
    tmr0_ovf_evt <= 1'b0;
    port_change_evt <= 1'b0;
    model[1] |= r[7:0] & 8'h7F;
    model[2] |= r[15:8] & 8'hFD;
    model[0] |= {t, 1'b0, p};
  endtask

  // Bounded wait for a counter to move; falling edges keep the look
  // clear of the counters' own rising edge; cyc reports the wait
  task automatic waitc(ref int c);
    int s;
    s = c;
    cyc = 0;
    while (c == s && cyc < 40) begin
      @(negedge clock);
      cyc++;
    end
  endtask

  task automatic pin(input logic v);
    @(posedge clock);
    ext_irq_pin <= v;
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Hang guard, well past the sequence length
  initial begin
    repeat (6000) @(posedge clock);
    n_fail++;
    stop_test();
  end

  initial begin
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    for (int i = 0; i < 9; i++) rdc(8'(i * 4));
    wr(8'h20, 8'hFF);
    rdc(8'h20);
    // Flags set with every enable clear
    seed = xs(seed);
    evt(seed[15:0], 1'b1, 1'b1);
    pin(1'b1);
    repeat (4) @(posedge clock);
    model[0] |= 2;
    for (int i = 0; i < 3; i++) rdc(8'(i * 4));
    wr(8'h0C, 8'hFF);
    wr(8'h10, 8'hFF);
    wr(8'h00, 8'h7F);
    repeat (40) @(posedge clock);
    rdc(8'h0C);
    rdc(8'h10);
    chk(n_take, 0);
    // Pending request is serviced once global enable is set
    wr(8'h00, 8'hFF);
    waitc(n_take);
    chk(n_take, 1);
    model[0] &= 8'h7F;
    rdc(8'h00);
    wr(8'h00, 8'h78);
    wr(8'h04, 8'h00);
    wr(8'h08, 8'h00);
    @(posedge clock);
    do_ret <= 1'b1;
    @(posedge clock);
    do_ret <= 1'b0;
    repeat (40) @(posedge clock);
    model[0] |= 8'h80;
    rdc(8'h00);
    chk(n_take, 1);
    // Falling edge latency
    wr(8'h18, 8'h00);
    pin(1'b0);
    waitc(n_take);
    chk({31'h0, n_take == 2 && cyc <= 16}, 1);
    model[0] = 8'h7A;
    rdc(8'h00);
    // Source without its enable never interrupts
    wr(8'h00, 8'h80);
    evt(16'h0000, 1'b1, 1'b0);
    repeat (40) @(posedge clock);
    chk(n_take, 2);
    rdc(8'h00);
    // Interrupt wake with global enable clear
    wr(8'h00, 8'h10);
    pin(1'b1);
    @(posedge clock);
    go_sleep <= 1'b1;
    @(posedge clock);
    go_sleep <= 1'b0;
    pin(1'b0);
    waitc(n_wake);
    chk(n_wake, 1);
    repeat (20) @(posedge clock);
    chk(n_take, 2);
    model[0] |= 2;
    rdc(8'h00);
    // Watchdog in sleep, master clear, watchdog awake, brown-out
    wr(8'h0C, 8'h55);
    wr(8'h00, 8'h81);
    wr(8'h14, 8'h0F);
    @(posedge clock);
    go_sleep <= 1'b1;
    @(posedge clock);
    go_sleep <= 1'b0;
    watchdog_timeout <= 1'b1;
    @(posedge clock);
    watchdog_timeout <= 1'b0;
    repeat (8) @(posedge clock);
    go_sleep <= 1'b1;
    @(posedge clock);
    go_sleep <= 1'b0;
    master_clear_pin_n <= 1'b0;
    repeat (10) @(posedge clock);
    master_clear_pin_n <= 1'b1;
    repeat (6) @(posedge clock);
    watchdog_timeout <= 1'b1;
    @(posedge clock);
    watchdog_timeout <= 1'b0;
    repeat (8) @(posedge clock);
    brownout_det <= 1'b1;
    repeat (10) @(posedge clock);
    brownout_det <= 1'b0;
    repeat (10) @(posedge clock);
    model[0] &= 1;
    model[3] = 0;
    model[4] = 0;
    model[5] = 6;
    model[6] = 8'h40;
    for (int i = 0; i < 7; i++) rdc(8'(i * 4));
    stop_test();
  end
endmodule

/* File: verification/micw_core_model.sv */
// Purpose: Behavioural core beside the interrupt and wake controller
// Assumes: Bench asks for sleep and return by one-cycle pulses
// Notes:   Every second instruction takes two cycles
`timescale 1ns/10ps
module micw_core_model (
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic core_wake,
  input  wire logic pc_load,
  input  wire logic go_sleep,
  input  wire logic do_ret,
  output logic      core_boundary,
  output logic      core_sleeping,
  output logic      core_return_from_irq_instr
);
  logic [3:0] cnt_r;

  // Boundary drops mid two-cycle instruction, so takes must wait
  assign core_boundary = (cnt_r < 4'h4) || (cnt_r > 4'h7);

  // Sleep ends on wake or on any reset vector load
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 4'h0;
      core_sleeping <= 1'b0;
      core_return_from_irq_instr <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == 4'hB) ? 4'h0 : cnt_r + 4'h1;
      core_return_from_irq_instr <= do_ret;
      if (core_wake || pc_load) begin
        core_sleeping <= 1'b0;
      end else if (go_sleep) begin
        core_sleeping <= 1'b1;
      end
    end
  end
endmodule

/* File: verification/micw_irq_wake_chk.sv */
// Purpose: Port assertions for the interrupt and wake controller
// Assumes: One clock domain; bound onto micw_irq_wake
// Notes:   Reset waits leave room for the input synchronisers
`timescale 1ns/10ps
module micw_irq_wake_chk (
  input wire logic        clock,
  input wire logic        arst_n,
  input wire logic        master_clear_pin_n,
  input wire logic        brownout_det,
  input wire logic        watchdog_timeout,
  input wire logic        core_sleeping,
  input wire logic        irq_take,
  input wire logic        pc_load,
  input wire logic [12:0] pc_value,
  input wire logic        status_load,
  input wire logic [4:0]  status_cause,
  input wire logic [4:0]  status_keep
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  // Taking a request vectors the core at once
  a_take_vector: assert property (
    irq_take |-> pc_load && pc_value == 13'h0004)
    else $error("take without vector load");
  // Global enable is cleared by a take, so no second take follows in the next three cycles
  a_take_gap: assert property (
    irq_take |=> !irq_take [*3])
    else $error("take repeated too soon");
  a_take_awake: assert property (
    irq_take |-> !$past(core_sleeping))
    else $error("take while core asleep");
  // Held master clear keeps the counter at zero
  a_master_clear_pin_vector: assert property (
    !master_clear_pin_n [*6] |-> pc_load && pc_value == 13'h0000)
    else $error("master clear without reset vector");
  a_master_clear_pin_status: assert property (
    !master_clear_pin_n [*6] |-> status_cause[4:2] == 3'b000)
    else $error("master clear status wrong");
  // Clear pulled while asleep reports TO set and PD clear
  a_master_clear_pin_sleep: assert property (
    $fell(master_clear_pin_n) && core_sleeping
      |-> ##3 (status_load && status_cause == 5'h02))
    else $error("master clear in sleep status wrong");
  a_wdt_vector: assert property (
    watchdog_timeout && !core_sleeping
      |-> ##[1:4] (pc_load && pc_value == 13'h0000))
    else $error("watchdog reset without reset vector");
  a_wdt_status: assert property (
    watchdog_timeout && !core_sleeping
      |-> ##[1:4] (status_load && status_cause[4:1] == 4'h0
                   && status_keep == 5'h01))
    else $error("watchdog reset status wrong");
  a_wdt_wake: assert property (
    watchdog_timeout && core_sleeping
      |-> ##[1:4] (status_load && status_cause[1:0] == 2'b00))
    else $error("watchdog wake status wrong");
  a_brown_vector: assert property (
    $rose(brownout_det) |-> ##[1:6]
      (pc_load && pc_value == 13'h0000 && status_cause == 5'h03))
    else $error("brown-out reset vector or status wrong");
endmodule

bind micw_irq_wake micw_irq_wake_chk u_chk (
  .clock              (clock),
  .arst_n             (arst_n),
  .master_clear_pin_n (master_clear_pin_n),
  .brownout_det       (brownout_det),
  .watchdog_timeout   (watchdog_timeout),
  .core_sleeping      (core_sleeping),
  .irq_take           (irq_take),
  .pc_load            (pc_load),
  .pc_value           (pc_value),
  .status_load        (status_load),
  .status_cause       (status_cause),
  .status_keep        (status_keep)
);
